// ### inc/ser_pkg.sv
package ser_pkg;
    localparam int SER_W = 15;
    localparam int SER_ERR_W = 16;
    localparam int SER_QDEPTH = 8;
    // register selectors on the command port
    localparam logic [3:0] SER_SEL_ACT_LIVE = 4'h0;
    localparam logic [3:0] SER_SEL_ACT_MASK = 4'h1;
    localparam logic [3:0] SER_SEL_ACT_EVT = 4'h2;
    localparam logic [3:0] SER_SEL_ACT_FALL = 4'h3;
    localparam logic [3:0] SER_SEL_ACT_RISE = 4'h4;
    localparam logic [3:0] SER_SEL_QUA_LIVE = 4'h5;
    localparam logic [3:0] SER_SEL_QUA_MASK = 4'h6;
    localparam logic [3:0] SER_SEL_QUA_EVT = 4'h7;
    localparam logic [3:0] SER_SEL_QUA_FALL = 4'h8;
    localparam logic [3:0] SER_SEL_QUA_RISE = 4'h9;
    localparam logic [3:0] SER_SEL_QUEUE = 4'ha;
    // values after reset and preset, and the empty queue code
    localparam logic [14:0] SER_RISE_PRESET = 15'h7fff;
    localparam logic [14:0] SER_FALL_PRESET = 15'h0000;
    localparam logic [14:0] SER_MASK_PRESET = 15'h0000;
    localparam logic [15:0] SER_NO_ERROR = 16'h0000;
endpackage

// ### rtl/ser_group.sv
`timescale 1ns/100ps
`default_nettype none
// one status group: live edge filters, sticky events, forward mask
module ser_group
    import ser_pkg::*;
#(
    parameter int W = SER_W
) (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // live state
    input wire logic [W-1:0] live,
    // control
    input wire logic preset,
    input wire logic evt_clear,
    input wire logic wr_mask,
    input wire logic wr_fall,
    input wire logic wr_rise,
    input wire logic [W-1:0] wdata,
    // state out
    output logic [W-1:0] live_q,
    output logic [W-1:0] evt_q,
    output logic [W-1:0] mask_q,
    output logic [W-1:0] fall_q,
    output logic [W-1:0] rise_q,
    output logic summary
);
    typedef struct packed {
        logic [W-1:0] live;
        logic [W-1:0] evt;
        logic [W-1:0] mask;
        logic [W-1:0] fall;
        logic [W-1:0] rise;
    } ser_grp_s;

    ser_grp_s s_q, s_d;
    logic [W-1:0] hit;

    always_comb begin
        s_d = s_q;
        s_d.live = live; // [RQ3]
        for (int i = 0; i < W; i++) begin
            hit[i] = (rise_q[i] & ~s_q.live[i] & live[i]) // [RQ5]
                | (fall_q[i] & s_q.live[i] & ~live[i]); // [RQ6]
        end
        // new edge wins over the read clear so no event is lost
        s_d.evt = (evt_clear ? '0 : s_q.evt) | hit; // [RQ4] [RQ17]
        if (wr_mask) begin
            s_d.mask = wdata; // [RQ2]
        end
        if (wr_fall) begin
            s_d.fall = wdata;
        end
        if (wr_rise) begin
            s_d.rise = wdata;
        end
        if (preset) begin
            s_d.rise = SER_RISE_PRESET[W-1:0]; // [RQ9]
            s_d.fall = SER_FALL_PRESET[W-1:0]; // [RQ10]
            s_d.mask = SER_MASK_PRESET[W-1:0]; // [RQ11]
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            s_q.live <= '0;
            s_q.evt <= '0;
            s_q.mask <= SER_MASK_PRESET[W-1:0];
            s_q.fall <= SER_FALL_PRESET[W-1:0];
            s_q.rise <= SER_RISE_PRESET[W-1:0];
        end else begin
            s_q <= s_d;
        end
    end

    assign live_q = s_q.live;
    assign evt_q = s_q.evt;
    assign mask_q = s_q.mask;
    assign fall_q = s_q.fall;
    assign rise_q = s_q.rise;
    assign summary = |(s_q.evt & s_q.mask); // [RQ16]
endmodule
`default_nettype wire

// ### rtl/ser_status.sv
// Overview of operation
// RQ1: every status part is 15 bits, reads give 0 to 32767.
// RQ2: configurable parts accept writes of 0 to 32767.
// RQ3: live state read returns hardware state and leaves it unchanged.
// RQ4: latched events read returns events since last read, then clears.
// RQ5: enabled rising filter bit latches event on 0-to-1 live change.
// RQ6: enabled falling filter bit latches event on 1-to-0; disabled records nothing.
// RQ7: forward mask selects latched events for the group summary bit.
// RQ8: enabled set event raises summary, a rising edge to next level.
// RQ9: preset loads every rising filter with all ones.
// RQ10: preset clears every falling filter to zero.
// RQ11: preset clears both forward masks to zero.
// RQ12: instrument reset command leaves all status parts unchanged.
// RQ13: queue read returns oldest entry and removes it, fifo order.
// RQ14: empty queue read returns code zero, no error.
// RQ15: positive codes are device errors, negative are language errors.
// RQ16: summary is OR of latched events ANDed with mask.
// RQ17: latched event stays set until read or cleared.
`timescale 1ns/100ps
`default_nettype none
module ser_status
    import ser_pkg::*;
#(
    parameter int W = SER_W,
    parameter int DEPTH = SER_QDEPTH
) (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // hardware live states
    input wire logic [W-1:0] act_live,
    input wire logic [W-1:0] qua_live,
    // command port
    input wire logic cmd_rd,
    input wire logic cmd_wr,
    input wire logic [3:0] cmd_sel,
    input wire logic [W-1:0] cmd_wdata,
    input wire logic cmd_preset,
    input wire logic cmd_inst_reset,
    // error push side, signed codes
    input wire logic err_push,
    input wire logic [SER_ERR_W-1:0] err_code,
    // answers
    output logic rd_valid,
    output logic [SER_ERR_W-1:0] rd_data,
    output logic act_summary,
    output logic qua_summary,
    output logic err_full,
    output logic err_empty
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic rd_valid;
        logic [SER_ERR_W-1:0] rd_data;
        logic act_sum;
        logic qua_sum;
        logic [AW-1:0] head;
        logic [AW-1:0] tail;
        logic [AW:0] count;
        logic full;
        logic empty;
        logic [DEPTH-1:0][SER_ERR_W-1:0] mem;
    } ser_top_s;

    // queue starts empty, everything else cleared
    localparam ser_top_s TOP_RESET = '{empty: 1'b1, default: '0};

    ser_top_s s_q, s_d;
    logic [W-1:0] a_live, a_evt, a_mask, a_fall, a_rise;
    logic [W-1:0] q_live, q_evt, q_mask, q_fall, q_rise;
    logic a_sum, q_sum;
    logic wr_ok, pop, push;

    // instrument reset command has no port into the groups at all [RQ12]
    assign wr_ok = cmd_wr & ~cmd_preset;
    assign pop = cmd_rd & (cmd_sel == SER_SEL_QUEUE) & (s_q.count != '0); // [RQ13]
    // a full queue drops the newest code, keeping the oldest ones intact
    assign push = err_push & ((s_q.count != (AW+1)'(DEPTH)) | pop);

    ser_group #(.W(W)) u_act (
        .clk(clk),
        .reset(reset),
        .live(act_live),
        .preset(cmd_preset),
        .evt_clear(cmd_rd & (cmd_sel == SER_SEL_ACT_EVT)),
        .wr_mask(wr_ok & (cmd_sel == SER_SEL_ACT_MASK)),
        .wr_fall(wr_ok & (cmd_sel == SER_SEL_ACT_FALL)),
        .wr_rise(wr_ok & (cmd_sel == SER_SEL_ACT_RISE)),
        .wdata(cmd_wdata),
        .live_q(a_live),
        .evt_q(a_evt),
        .mask_q(a_mask),
        .fall_q(a_fall),
        .rise_q(a_rise),
        .summary(a_sum)
    );

    ser_group #(.W(W)) u_qua (
        .clk(clk),
        .reset(reset),
        .live(qua_live),
        .preset(cmd_preset),
        .evt_clear(cmd_rd & (cmd_sel == SER_SEL_QUA_EVT)),
        .wr_mask(wr_ok & (cmd_sel == SER_SEL_QUA_MASK)),
        .wr_fall(wr_ok & (cmd_sel == SER_SEL_QUA_FALL)),
        .wr_rise(wr_ok & (cmd_sel == SER_SEL_QUA_RISE)),
        .wdata(cmd_wdata),
        .live_q(q_live),
        .evt_q(q_evt),
        .mask_q(q_mask),
        .fall_q(q_fall),
        .rise_q(q_rise),
        .summary(q_sum)
    );

    always_comb begin
        s_d = s_q;
        s_d.rd_valid = cmd_rd;
        s_d.act_sum = a_sum; // [RQ7] [RQ8]
        s_d.qua_sum = q_sum; // [RQ7] [RQ8]
        s_d.rd_data = '0;
        if (cmd_rd) begin
            case (cmd_sel)
                // parts are zero-extended, so reads never pass 32767 [RQ1]
                SER_SEL_ACT_LIVE: s_d.rd_data = {1'b0, a_live};
                SER_SEL_ACT_MASK: s_d.rd_data = {1'b0, a_mask};
                SER_SEL_ACT_EVT: s_d.rd_data = {1'b0, a_evt}; // [RQ4]
                SER_SEL_ACT_FALL: s_d.rd_data = {1'b0, a_fall};
                SER_SEL_ACT_RISE: s_d.rd_data = {1'b0, a_rise};
                SER_SEL_QUA_LIVE: s_d.rd_data = {1'b0, q_live};
                SER_SEL_QUA_MASK: s_d.rd_data = {1'b0, q_mask};
                SER_SEL_QUA_EVT: s_d.rd_data = {1'b0, q_evt}; // [RQ4]
                SER_SEL_QUA_FALL: s_d.rd_data = {1'b0, q_fall};
                SER_SEL_QUA_RISE: s_d.rd_data = {1'b0, q_rise};
                SER_SEL_QUEUE: begin
                    // codes pass through signed unchanged [RQ15]
                    s_d.rd_data = pop ? s_q.mem[s_q.head] : SER_NO_ERROR; // [RQ13] [RQ14]
                end
                default: s_d.rd_data = '0;
            endcase
        end
        if (pop) begin
            s_d.head = s_q.head + 1'b1;
        end
        if (push) begin
            s_d.tail = s_q.tail + 1'b1;
            s_d.mem[s_q.tail] = err_code;
        end
        s_d.count = s_q.count + (AW+1)'(push) - (AW+1)'(pop);
        // flags follow the new count so they agree with it in every cycle
        s_d.full = (s_d.count == (AW+1)'(DEPTH));
        s_d.empty = (s_d.count == '0);
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            s_q <= TOP_RESET;
        end else begin
            s_q <= s_d;
        end
    end

    assign rd_valid = s_q.rd_valid;
    assign rd_data = s_q.rd_data;
    assign act_summary = s_q.act_sum;
    assign qua_summary = s_q.qua_sum;
    assign err_full = s_q.full;
    assign err_empty = s_q.empty;
endmodule
`default_nettype wire

// ### test/ser_status_monitor.sv
`timescale 1ns/100ps
`default_nettype none
module ser_status_monitor
    import ser_pkg::*;
#(
    parameter int W = SER_W,
    parameter int DEPTH = SER_QDEPTH
) (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // requests
    input wire logic [W-1:0] act_live,
    input wire logic cmd_rd,
    input wire logic cmd_wr,
    input wire logic [3:0] cmd_sel,
    input wire logic cmd_preset,
    input wire logic err_push,
    // answers
    input wire logic rd_valid,
    input wire logic [SER_ERR_W-1:0] rd_data,
    input wire logic act_summary,
    input wire logic qua_summary,
    input wire logic err_empty
);
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    sequence s_qrd_empty; cmd_rd && cmd_sel == SER_SEL_QUEUE && err_empty && !err_push; endsequence
    sequence s_quiet; !$past(cmd_rd) && !$past(cmd_wr) && !$past(cmd_preset); endsequence
    property p_rd_answer; cmd_rd |=> rd_valid; endproperty
    property p_rd_idle; !cmd_rd |=> !rd_valid && rd_data == 16'h0000; endproperty
    property p_rd_width; rd_valid && $past(cmd_sel) != SER_SEL_QUEUE |-> !rd_data[15]; endproperty
    property p_live_read;
        cmd_rd && cmd_sel == SER_SEL_ACT_LIVE && !$past(reset) |=> rd_data == 16'($past(act_live, 2));
    endproperty
    property p_empty_zero; s_qrd_empty |=> rd_data == SER_NO_ERROR; endproperty
    property p_preset_mask; cmd_preset |-> ##2 !act_summary && !qua_summary; endproperty
    property p_push_fill; err_empty && err_push && !cmd_rd |=> !err_empty; endproperty
    property p_act_sticky; act_summary ##0 s_quiet |=> act_summary; endproperty
    property p_qua_sticky; qua_summary ##0 s_quiet |=> qua_summary; endproperty
    a_rd_answer: assert property (p_rd_answer) else $error("read not answered");
    a_rd_idle: assert property (p_rd_idle) else $error("answer without read");
    a_rd_width: assert property (p_rd_width) else $error("part wider than 15");
    a_live_read: assert property (p_live_read) else $error("live read wrong");
    a_empty_zero: assert property (p_empty_zero) else $error("empty pop not 0");
    a_preset_mask: assert property (p_preset_mask) else $error("mask kept");
    a_push_fill: assert property (p_push_fill) else $error("push lost");
    a_act_sticky: assert property (p_act_sticky) else $error("event lost");
    a_qua_sticky: assert property (p_qua_sticky) else $error("event lost");
endmodule
bind ser_status ser_status_monitor #(.W(W), .DEPTH(DEPTH)) mon_u (
    .clk(clk),
    .reset(reset),
    .act_live(act_live),
    .cmd_rd(cmd_rd),
    .cmd_wr(cmd_wr),
    .cmd_sel(cmd_sel),
    .cmd_preset(cmd_preset),
    .err_push(err_push),
    .rd_valid(rd_valid),
    .rd_data(rd_data),
    .act_summary(act_summary),
    .qua_summary(qua_summary),
    .err_empty(err_empty)
);
`default_nettype wire

// ### test/status_event_reporting_tb.sv
`timescale 1ns/100ps
`default_nettype none
module status_event_reporting_tb
    import ser_pkg::*;
;
    logic clk = 0, reset = 1, cmd_rd = 0, cmd_wr = 0, cmd_preset = 0, cmd_inst_reset = 0;
    logic err_push = 0, rd_valid, act_summary, qua_summary, err_full, err_empty;
    logic [14:0] act_live = 0, qua_live = 0, cmd_wdata = 0, a, b, c, r, f, m, e;
    logic [3:0] cmd_sel = 0;
    logic [15:0] err_code = 0, rd_data, v;
    logic [15:0] q[$];
    int mismatches = 0, checks_done = 0, seed = 10, g, s;
    int cfg[6] = '{1, 3, 4, 6, 8, 9};
    always #50 clk = ~clk;
    ser_status dut_u (
        .clk(clk),
        .reset(reset),
        .act_live(act_live),
        .qua_live(qua_live),
        .cmd_rd(cmd_rd),
        .cmd_wr(cmd_wr),
        .cmd_sel(cmd_sel),
        .cmd_wdata(cmd_wdata),
        .cmd_preset(cmd_preset),
        .cmd_inst_reset(cmd_inst_reset),
        .err_push(err_push),
        .err_code(err_code),
        .rd_valid(rd_valid),
        .rd_data(rd_data),
        .act_summary(act_summary),
        .qua_summary(qua_summary),
        .err_full(err_full),
        .err_empty(err_empty)
    );
    function automatic logic [14:0] edges(input logic [14:0] x, y);
        return (~x & y & r) | (x & ~y & f);
    endfunction
    task automatic chk(input string n, input logic [15:0] seen, exp);
        checks_done++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", n, exp, seen);
        end
    endtask
    task automatic acc(input int sel, input logic w, input logic [14:0] d);
        @(posedge clk);
        cmd_sel <= 4'(sel);
        cmd_wr <= w;
        cmd_rd <= !w;
        cmd_wdata <= d;
        @(posedge clk);
        cmd_wr <= 0;
        cmd_rd <= 0;
        @(negedge clk);
        v = rd_data;
        chk("rd_valid", 16'(rd_valid), 16'(!w));
    endtask
    // event and summary need a few cycles after the live input moves
    task automatic live(input logic [14:0] x);
        @(posedge clk);
        if (g) qua_live <= x;
        else act_live <= x;
        repeat (4) @(posedge clk);
        @(negedge clk);
    endtask
    task automatic defaults;
        for (s = 1; s < 10; s++) begin
            if (s % 5 inside {1, 3, 4}) begin
                acc(s, 0, 0);
                chk("default", v, s % 5 == 4 ? 16'h7fff : 16'h0);
            end
        end
    endtask
    task automatic complete_run;
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        repeat (2) @(posedge clk);
        reset <= 0;
        defaults;
        repeat (20) begin
            s = cfg[$unsigned($random(seed)) % 6];
            a = 15'($random(seed));
            acc(s, 1, a);
            acc(s, 0, 0);
            chk("config", v, {1'b0, a});
        end
        g = 0;
        live(15'h7fff);
        acc(SER_SEL_ACT_LIVE, 1, 15'h0);
        repeat (2) begin
            acc(SER_SEL_ACT_LIVE, 0, 0);
            chk("live", v, 16'h7fff);
        end
        for (g = 0; g < 2; g++) begin
            {a, b, c, r, f, m} = 90'({$random(seed), $random(seed), $random(seed)});
            acc(4 + 5 * g, 1, r);
            acc(3 + 5 * g, 1, f);
            acc(1 + 5 * g, 1, m);
            live(a);
            acc(2 + 5 * g, 0, 0);
            live(b);
            e = edges(a, b);
            chk("summary", 16'(g ? qua_summary : act_summary), 16'(|(e & m)));
            live(c);
            acc(2 + 5 * g, 0, 0);
            chk("events", v, {1'b0, e | edges(b, c)});
            acc(2 + 5 * g, 0, 0);
            chk("cleared", v, 16'h0);
            @(posedge clk);
            cmd_inst_reset <= 1;
            @(posedge clk);
            cmd_inst_reset <= 0;
            acc(4 + 5 * g, 0, 0);
            chk("kept", v, {1'b0, r});
        end
        @(posedge clk);
        cmd_preset <= 1;
        @(posedge clk);
        cmd_preset <= 0;
        defaults;
        chk("summaries", 16'({act_summary, qua_summary}), 16'h0);
        chk("empty", 16'(err_empty), 16'h1);
        for (s = 0; s <= SER_QDEPTH; s++) begin
            @(posedge clk);
            v = 16'($random(seed));
            err_push <= 1;
            err_code <= v;
            if (s < SER_QDEPTH) q.push_back(v);
        end
        @(posedge clk);
        err_push <= 0;
        @(negedge clk);
        chk("full", 16'(err_full), 16'h1);
        repeat (SER_QDEPTH + 1) begin
            acc(SER_SEL_QUEUE, 0, 0);
            chk("queue", v, q.size() ? q.pop_front() : SER_NO_ERROR);
        end
        chk("drained", 16'({err_full, err_empty}), 16'h1);
        complete_run;
    end
endmodule
`default_nettype wire
